// ===== cps_pkg.sv
// Constants, register map and types of the loop control selector.
// Assumes a 100 MHz clock and a byte-addressed plain register port.
package cps_pkg;

  // Clock and time base.
  localparam int unsigned CPS_CLK_PERIOD_NS = 10;
  localparam int unsigned CPS_MS_NS = 1000000;
  localparam int unsigned CPS_MS_CYCLES = CPS_MS_NS / CPS_CLK_PERIOD_NS;

  // Control periods and outage limits, in milliseconds.
  localparam logic [9:0] CPS_PERIOD_250_MS = 10'd250;
  localparam logic [9:0] CPS_PERIOD_500_MS = 10'd500;
  localparam logic [9:0] CPS_PERIOD_1S_MS = 10'd1000;
  localparam logic [12:0] CPS_OUTAGE_SHORT_MS = 13'd2000;
  localparam logic [12:0] CPS_OUTAGE_LONG_MS = 13'd5000;

  // Register byte addresses.
  localparam logic [7:0] CPS_CFG_ADDR = 8'h00;
  localparam logic [7:0] CPS_SPSEL_ADDR = 8'h04;
  localparam logic [7:0] CPS_RAMP_ADDR = 8'h08;
  localparam logic [7:0] CPS_MODE_ADDR = 8'h0c;
  localparam logic [7:0] CPS_DEV_ADDR = 8'h10;
  localparam logic [7:0] CPS_SWLIM_ADDR = 8'h14;
  localparam logic [7:0] CPS_OUTLIM_ADDR = 8'h18;
  localparam logic [7:0] CPS_PID_ADDR = 8'h1c;
  localparam logic [7:0] CPS_STAT_ADDR = 8'h20;
  localparam logic [7:0] CPS_PV_ADDR = 8'h24;
  localparam logic [7:0] CPS_SP_BASE = 8'h40;
  localparam logic [7:0] CPS_REF_BASE = 8'h60;

  // Configuration field positions.
  localparam int unsigned CPS_CFG_PERIOD = 0;
  localparam int unsigned CPS_CFG_ADC100 = 2;
  localparam int unsigned CPS_CFG_ZONE = 3;
  localparam int unsigned CPS_CFG_GROUPS = 4;
  localparam int unsigned CPS_CFG_LOOPS4 = 7;
  localparam int unsigned CPS_CFG_RESTART = 8;
  localparam int unsigned CPS_CFG_FLOWDEF = 10;
  localparam int unsigned CPS_CFG_PVCALC = 11;
  localparam int unsigned CPS_CFG_LOADDEF = 12;

  // Values after reset.
  localparam logic [2:0] CPS_GROUPS_RST = 3'h7;
  localparam logic [15:0] CPS_SPAN_RST = 16'h03e8;

  // Default PID constants: band in 0.1 %, times in seconds.
  localparam logic [11:0] CPS_TEMP_PB = 12'h032;
  localparam logic [9:0] CPS_TEMP_TI = 10'h0f0;
  localparam logic [9:0] CPS_TEMP_TD = 10'h03c;
  localparam logic [11:0] CPS_FLOW_PB = 12'h4b0;
  localparam logic [9:0] CPS_FLOW_TI = 10'h014;
  localparam logic [9:0] CPS_FLOW_TD = 10'h000;

  typedef enum logic [1:0] {CPS_P250, CPS_P500, CPS_P1S} cps_period_type;
  typedef enum logic [1:0] {
    CPS_SINGLE, CPS_CASCADE, CPS_PVSWITCH, CPS_RETRANS
  } cps_mode_type;
  typedef enum logic [1:0] {
    CPS_SW_RANGE, CPS_SW_UPPER, CPS_SW_SIGNAL
  } cps_method_type;
  typedef enum logic [1:0] {
    CPS_RS_CONTINUE, CPS_RS_MANUAL, CPS_RS_AUTO, CPS_RS_STOP
  } cps_restart_type;

endpackage : cps_pkg

// ===== cps_selector.sv
// Control period, parameter group, restart and loop mode selection.
// Assumes pins arrive asynchronously and the PID core sits outside.
//
// Behaviour
// - Period 250 ms, 500 ms, 1 s; 250 default.
// - One period shared by all loops.
// - 100 ms integration forces 1 s period.
// - Process values sampled once per period.
// - Up to eight setpoints selectable any time.
// - Setpoint moves at ramp-up or ramp-down rate.
// - Parameter group follows selected setpoint number.
// - Zones: reference points equal groups minus two.
// - Zone containing process value picks group.
// - Large deviation picks highest group.
// - Long outage: configured manual, auto without program, stop in program; else continue.
// - Short outage continues prior operation.
// - Temperature defaults 5.0 %, 240 s, 60 s.
// - Flow defaults 120.0 %, 20 s, 0 s.
// - Six loops: loops five, six single only.
// - Independent control mode for every loop.
// - Cascade feeds primary output as secondary setpoint.
// - Range switching blends both inputs by weight.
// - Upper switching with half percent hysteresis.
// - Contact selects first or second input.
// - Retransmission outputs computed value unlimited.
// - Computed process value replaces input terminals.
// - Group count one to eight limits indices.
`timescale 1ns/1ps
`default_nettype none

module cps_selector
  import cps_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CPS_MS_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic signed [15:0] first_measured_input,
  input wire logic signed [15:0] second_measured_input,
  input wire logic signed [15:0] computed_pv,
  input wire logic signed [15:0] computed_out,
  input wire logic signed [15:0] pid_out,
  input wire logic pv_switch_contact,
  input wire logic power_good,
  input wire logic program_active,
  output logic period_tick,
  output logic signed [15:0] pv_q,
  output logic signed [15:0] setpoint_q,
  output logic signed [15:0] secondary_setpoint_q,
  output logic signed [15:0] ctrl_out_q,
  output logic [2:0] group_q,
  output logic [11:0] loop_mode,
  output logic [1:0] restart_action_q,
  output logic restart_pulse_q
);

  // Software-held configuration.
  logic [12:0] cfg_q;
  logic [2:0] sp_sel_q;
  logic [15:0] ramp_up_q, ramp_dn_q;
  logic [23:0] mode_q;
  logic [15:0] dev_ref_q, span_q;
  logic signed [15:0] sw_lo_q, sw_hi_q, out_lo_q, out_hi_q;
  logic signed [15:0] sp_tab_q [8];
  logic signed [15:0] ref_tab_q [6];
  logic [11:0] pb_q;
  logic [9:0] ti_q, td_q;

  logic wr_cfg, sel2_q;
  logic [16:0] ms_cnt_q;
  logic [9:0] per_ms_q, per_len;
  logic [12:0] out_ms_q;
  logic [2:0] contact_s, power_s;
  logic contact_q, power_q, power_prev_q;
  logic [2:0] grp_max, n_refs, zone_cnt;
  logic [5:0] above;
  logic signed [15:0] pv_sel, sp_target, pv_next;
  logic signed [16:0] d1, dd, den, dev;
  logic signed [33:0] quot;
  cps_mode_type mode0;
  cps_method_type meth0;

  assign wr_cfg = reg_wr && reg_addr == CPS_CFG_ADDR;
  assign grp_max = cfg_q[CPS_CFG_GROUPS +: 3];

  // Configuration writes; setpoint and reference tables sit in word arrays.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_q <= {1'b0, 1'b0, 1'b0, 2'h0, 1'b0, CPS_GROUPS_RST, 1'b0, 1'b0,
                2'h0};
      sp_sel_q <= 3'h0;
      ramp_up_q <= 16'h0000;
      ramp_dn_q <= 16'h0000;
      mode_q <= 24'h000000;
      dev_ref_q <= 16'h7fff;
      span_q <= CPS_SPAN_RST;
      sw_lo_q <= 16'h0000;
      sw_hi_q <= 16'h0000;
      out_lo_q <= 16'h8000;
      out_hi_q <= 16'h7fff;
      for (int i = 0; i < 8; i++) begin
        sp_tab_q[i] <= 16'h0000;
      end
      for (int i = 0; i < 6; i++) begin
        ref_tab_q[i] <= 16'h0000;
      end
    end else if (reg_wr) begin
      unique case (reg_addr)
        CPS_CFG_ADDR: cfg_q <= {1'b0, reg_wdata[11:0]};
        CPS_SPSEL_ADDR: sp_sel_q <= reg_wdata[2:0];
        CPS_RAMP_ADDR: begin
          ramp_up_q <= reg_wdata[15:0];
          ramp_dn_q <= reg_wdata[31:16];
        end
        CPS_MODE_ADDR: mode_q <= reg_wdata[23:0];
        CPS_DEV_ADDR: begin
          dev_ref_q <= reg_wdata[15:0];
          span_q <= reg_wdata[31:16];
        end
        CPS_SWLIM_ADDR: begin
          sw_lo_q <= reg_wdata[15:0];
          sw_hi_q <= reg_wdata[31:16];
        end
        CPS_OUTLIM_ADDR: begin
          out_lo_q <= reg_wdata[15:0];
          out_hi_q <= reg_wdata[31:16];
        end
        default: begin
          if (reg_addr[7:5] == CPS_SP_BASE[7:5] && reg_addr[1:0] == 2'h0) begin
            sp_tab_q[reg_addr[4:2]] <= reg_wdata[15:0];
          end else if (reg_addr[7:5] == CPS_REF_BASE[7:5] &&
                       reg_addr[4:2] < 3'h6 && reg_addr[1:0] == 2'h0) begin
            ref_tab_q[reg_addr[4:2]] <= reg_wdata[15:0];
          end
        end
      endcase
    end
  end

  // Default PID constants load at reset and on a load command.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pb_q <= CPS_TEMP_PB;
      ti_q <= CPS_TEMP_TI;
      td_q <= CPS_TEMP_TD;
    end else if (wr_cfg && reg_wdata[CPS_CFG_LOADDEF]) begin
      pb_q <= reg_wdata[CPS_CFG_FLOWDEF] ? CPS_FLOW_PB : CPS_TEMP_PB;
      ti_q <= reg_wdata[CPS_CFG_FLOWDEF] ? CPS_FLOW_TI : CPS_TEMP_TI;
      td_q <= reg_wdata[CPS_CFG_FLOWDEF] ? CPS_FLOW_TD : CPS_TEMP_TD;
    end
  end

  // One period for every loop; slow integration overrides the choice.
  always_comb begin
    if (cfg_q[CPS_CFG_ADC100]) begin
      per_len = CPS_PERIOD_1S_MS;
    end else begin
      unique case (cfg_q[CPS_CFG_PERIOD +: 2])
        CPS_P500: per_len = CPS_PERIOD_500_MS;
        CPS_P1S: per_len = CPS_PERIOD_1S_MS;
        default: per_len = CPS_PERIOD_250_MS;
      endcase
    end
  end

  // Millisecond prescaler and the shared period counter.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ms_cnt_q <= 17'h00000;
      per_ms_q <= 10'h000;
    end else if (ms_cnt_q == 17'(MS_CYCLES - 1)) begin
      ms_cnt_q <= 17'h00000;
      per_ms_q <= (per_ms_q >= per_len - 10'h001) ? 10'h000
                  : per_ms_q + 10'h001;
    end else begin
      ms_cnt_q <= ms_cnt_q + 17'h00001;
    end
  end
  assign period_tick = ms_cnt_q == 17'(MS_CYCLES - 1) &&
                       per_ms_q >= per_len - 10'h001;

  // Pins pass three flops; a level is taken once the last two agree.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      contact_s <= 3'h0;
      power_s <= 3'h7;
      contact_q <= 1'b0;
      power_q <= 1'b1;
    end else begin
      contact_s <= {contact_s[1:0], pv_switch_contact};
      power_s <= {power_s[1:0], power_good};
      if (contact_s[2] == contact_s[1]) begin
        contact_q <= contact_s[2];
      end
      if (power_s[2] == power_s[1]) begin
        power_q <= power_s[2];
      end
    end
  end

  // Outage length decides which restart path applies on recovery.
  // Outages between 2 s and 5 s are treated as short ones.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      out_ms_q <= 13'h0000;
      power_prev_q <= 1'b1;
      restart_action_q <= CPS_RS_CONTINUE;
      restart_pulse_q <= 1'b0;
    end else begin
      power_prev_q <= power_q;
      restart_pulse_q <= power_q && !power_prev_q;
      if (!power_q && ms_cnt_q == 17'(MS_CYCLES - 1) &&
          out_ms_q < CPS_OUTAGE_LONG_MS) begin
        out_ms_q <= out_ms_q + 13'h0001;
      end else if (power_q && !power_prev_q) begin
        out_ms_q <= 13'h0000;
      end
      if (power_q && !power_prev_q) begin
        if (out_ms_q < CPS_OUTAGE_LONG_MS) begin
          restart_action_q <= CPS_RS_CONTINUE;
        end else if ((cfg_q[CPS_CFG_RESTART +: 2] == CPS_RS_AUTO &&
                      program_active) ||
                     (cfg_q[CPS_CFG_RESTART +: 2] == CPS_RS_STOP &&
                      !program_active)) begin
          restart_action_q <= CPS_RS_CONTINUE;
        end else begin
          restart_action_q <= cfg_q[CPS_CFG_RESTART +: 2];
        end
      end
    end
  end

  // Per-loop mode; in six-loop use loops five and six run single only.
  genvar gl;
  generate
    for (gl = 0; gl < 6; gl++) begin : g_loop
      assign loop_mode[2*gl +: 2] =
        (gl >= 4 && !cfg_q[CPS_CFG_LOOPS4]) ? CPS_SINGLE
        : mode_q[4*gl +: 2];
    end
  endgenerate
  assign mode0 = cps_mode_type'(loop_mode[1:0]);
  assign meth0 = cps_method_type'(mode_q[3:2]);

  // Range blend terms for the first loop's input switching.
  assign d1 = 17'(first_measured_input) - 17'(sw_lo_q);
  assign dd = 17'(second_measured_input) - 17'(first_measured_input);
  assign den = 17'(sw_hi_q) - 17'(sw_lo_q);
  assign quot = (den > 17'sh00000) ? (34'(d1) * 34'(dd)) / 34'(den)
                : 34'sh000000000;

  // Process value source for the first loop.
  always_comb begin
    pv_sel = first_measured_input;
    if (cfg_q[CPS_CFG_PVCALC]) begin
      pv_sel = computed_pv;
    end else if (mode0 == CPS_PVSWITCH) begin
      unique case (meth0)
        CPS_SW_RANGE: begin
          if (first_measured_input <= sw_lo_q) begin
            pv_sel = first_measured_input;
          end else if (second_measured_input >= sw_hi_q) begin
            pv_sel = second_measured_input;
          end else begin
            pv_sel = 16'(17'(first_measured_input) + quot[16:0]);
          end
        end
        CPS_SW_UPPER: pv_sel = sel2_q ? second_measured_input
                               : first_measured_input;
        CPS_SW_SIGNAL: pv_sel = contact_q ? second_measured_input
                                : first_measured_input;
        default: pv_sel = first_measured_input;
      endcase
    end
  end

  // Upper-limit switching holds its choice inside a band of span/200.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sel2_q <= 1'b0;
    end else if (first_measured_input > sw_hi_q) begin
      sel2_q <= 1'b1;
    end else if (17'(first_measured_input) <=
                 17'(sw_hi_q) - $signed({1'b0, span_q / 16'd200})) begin
      sel2_q <= 1'b0;
    end
  end

  // Zone membership: one comparator per configured reference point.
  assign n_refs = (grp_max >= 3'h2) ? grp_max - 3'h1 : 3'h0;
  generate
    for (gl = 0; gl < 6; gl++) begin : g_zone
      assign above[gl] = (3'(gl) < n_refs) && (pv_q >= ref_tab_q[gl]);
    end
  endgenerate
  always_comb begin
    zone_cnt = 3'h0;
    for (int i = 0; i < 6; i++) begin
      zone_cnt = zone_cnt + {2'h0, above[i]};
    end
  end

  // Target setpoint, ramped each period, and the deviation from it.
  assign sp_target = sp_tab_q[(sp_sel_q > grp_max) ? grp_max : sp_sel_q];
  assign dev = (17'(setpoint_q) >= 17'(pv_q))
               ? 17'(setpoint_q) - 17'(pv_q) : 17'(pv_q) - 17'(setpoint_q);
  assign pv_next = pv_sel;

  // Sampling and setpoint ramp run only on the period tick.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pv_q <= 16'h0000;
      setpoint_q <= 16'h0000;
    end else if (period_tick) begin
      pv_q <= pv_next;
      // Rates enter a signed compare, so a fall never reads as a rise.
      if (17'(sp_target) - 17'(setpoint_q) > $signed({1'b0, ramp_up_q}) &&
          ramp_up_q != 16'h0000) begin
        setpoint_q <= setpoint_q + ramp_up_q;
      end else if (17'(setpoint_q) - 17'(sp_target) >
                   $signed({1'b0, ramp_dn_q}) && ramp_dn_q != 16'h0000) begin
        setpoint_q <= setpoint_q - ramp_dn_q;
      end else begin
        setpoint_q <= sp_target;
      end
    end
  end

  // Group choice: setpoint number, or zone with deviation override.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      group_q <= 3'h0;
    end else if (!cfg_q[CPS_CFG_ZONE]) begin
      group_q <= (sp_sel_q > grp_max) ? grp_max : sp_sel_q;
    end else if (dev > 17'(dev_ref_q)) begin
      group_q <= grp_max;
    end else begin
      group_q <= zone_cnt;
    end
  end

  // Output path: limits apply to PID results at ctrl_out_q, not to the cascade secondary setpoint, never to retransmission.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_out_q <= 16'h0000;
      secondary_setpoint_q <= 16'h0000;
    end else begin
      secondary_setpoint_q <= (mode0 == CPS_CASCADE) ? pid_out
                              : setpoint_q;
      if (mode0 == CPS_RETRANS) begin
        ctrl_out_q <= computed_out;
      end else if (pid_out > out_hi_q) begin
        ctrl_out_q <= out_hi_q;
      end else if (pid_out < out_lo_q) begin
        ctrl_out_q <= out_lo_q;
      end else begin
        ctrl_out_q <= pid_out;
      end
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clock) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else begin
      unique case (reg_addr)
        CPS_CFG_ADDR: reg_rdata <= {19'h00000, cfg_q};
        CPS_SPSEL_ADDR: reg_rdata <= {29'h00000000, sp_sel_q};
        CPS_RAMP_ADDR: reg_rdata <= {ramp_dn_q, ramp_up_q};
        CPS_MODE_ADDR: reg_rdata <= {8'h00, mode_q};
        CPS_DEV_ADDR: reg_rdata <= {span_q, dev_ref_q};
        CPS_SWLIM_ADDR: reg_rdata <= {sw_hi_q, sw_lo_q};
        CPS_OUTLIM_ADDR: reg_rdata <= {out_hi_q, out_lo_q};
        CPS_PID_ADDR: reg_rdata <= {td_q, ti_q, pb_q};
        CPS_STAT_ADDR: reg_rdata <= {8'h00, loop_mode, per_len,
                                     restart_action_q};
        CPS_PV_ADDR: reg_rdata <= {pv_q, 13'h0000, group_q};
        default: begin
          if (reg_addr[7:5] == CPS_SP_BASE[7:5] && reg_addr[1:0] == 2'h0) begin
            reg_rdata <= {16'h0000, sp_tab_q[reg_addr[4:2]]};
          end else if (reg_addr[7:5] == CPS_REF_BASE[7:5] &&
                       reg_addr[4:2] < 3'h6 && reg_addr[1:0] == 2'h0) begin
            reg_rdata <= {16'h0000, ref_tab_q[reg_addr[4:2]]};
          end else begin
            reg_rdata <= 32'h00000000;
          end
        end
      endcase
    end
  end

  // Checks on the selection logic.
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_restart;
    power_q && !power_prev_q;
  endsequence

  property p_period_rst;
    $fell(sys_rst) |-> per_len == CPS_PERIOD_250_MS;
  endproperty
  a_period_rst: assert property (p_period_rst)
    else $error("period after reset not 250 ms");

  property p_adc_force;
    cfg_q[CPS_CFG_ADC100] |-> per_len == CPS_PERIOD_1S_MS;
  endproperty
  a_adc_force: assert property (p_adc_force)
    else $error("integration setting did not force 1 s");

  property p_pv_hold;
    !period_tick |=> $stable(pv_q);
  endproperty
  a_pv_hold: assert property (p_pv_hold)
    else $error("pv changed between period ticks");

  property p_ramp;
    period_tick && ramp_up_q != 16'h0000 |=>
      17'(setpoint_q) - 17'($past(setpoint_q)) <=
        $signed({1'b0, $past(ramp_up_q)});
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("setpoint rose faster than ramp rate");

  property p_group_sp;
    !cfg_q[CPS_CFG_ZONE] && sp_sel_q <= grp_max ##1
      $stable(sp_sel_q) && $stable(cfg_q) |=> group_q == $past(sp_sel_q);
  endproperty
  a_group_sp: assert property (p_group_sp)
    else $error("group does not follow setpoint number");

  property p_dev;
    cfg_q[CPS_CFG_ZONE] && dev > 17'(dev_ref_q) |=> group_q == $past(grp_max);
  endproperty
  a_dev: assert property (p_dev)
    else $error("deviation override did not pick top group");

  property p_loop56;
    !cfg_q[CPS_CFG_LOOPS4] |-> loop_mode[11:8] == 4'h0;
  endproperty
  a_loop56: assert property (p_loop56)
    else $error("loops five and six not single in six-loop use");

  property p_retrans;
    mode0 == CPS_RETRANS |=> ctrl_out_q == $past(computed_out);
  endproperty
  a_retrans: assert property (p_retrans)
    else $error("retransmission output not the computed value");

  property p_short;
    s_restart and (out_ms_q < CPS_OUTAGE_LONG_MS) |=>
      restart_action_q == CPS_RS_CONTINUE && restart_pulse_q;
  endproperty
  a_short: assert property (p_short)
    else $error("short outage did not continue operation");

  property p_calc;
    cfg_q[CPS_CFG_PVCALC] && period_tick |=> pv_q == $past(computed_pv);
  endproperty
  a_calc: assert property (p_calc)
    else $error("computed pv not used");

endmodule : cps_selector

`default_nettype wire

// ===== cps_field.sv
// Far-side model: process sensors, switching contact and supply pin.
// Assumes the bench calls its tasks; levels change just after an edge.
`timescale 1ns/1ps
`default_nettype none

module cps_field (
  input wire logic clock,
  output logic signed [15:0] pv_a,
  output logic signed [15:0] pv_b,
  output logic contact,
  output logic power
);
  // Sensors read zero, contact is open and supply is present at start.
  initial begin
    pv_a = '0;
    pv_b = '0;
    contact = 1'b0;
    power = 1'b1;
  end

  // Both sensors and the contact move together, as a front end would.
  task automatic set_in(input int a, input int b, input bit c);
    @(posedge clock);
    pv_a <= 16'(a);
    pv_b <= 16'(b);
    contact <= c;
  endtask : set_in

  // The supply drops for n cycles; the selector filters the pin itself.
  task automatic outage(input int n);
    @(posedge clock);
    power <= 1'b0;
    repeat (n) @(posedge clock);
    power <= 1'b1;
  endtask : outage
endmodule : cps_field
`default_nettype wire

// ===== control_loop_pid_selector_test.sv
// Self-checking bench of the loop control selector.
// Assumes MS_CYCLES of 2, so a 250 ms period lasts 500 cycles.
`timescale 1ns/1ps
`default_nettype none

module control_loop_pid_selector_test import cps_pkg::*;;
  localparam int MS = 2;
  logic clock, sys_rst, reg_wr, reg_rd, program_active, period_tick;
  logic pv_switch_contact, power_good, restart_pulse_q;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [31:0] seed = 32'h40db;
  logic signed [15:0] first_measured_input, second_measured_input;
  logic signed [15:0] computed_pv, computed_out, pid_out, pv_q;
  logic signed [15:0] setpoint_q, secondary_setpoint_q, ctrl_out_q;
  logic [2:0] group_q;
  logic [11:0] loop_mode;
  logic [1:0] restart_action_q;
  int failures, num_checks, n, g, v;
  // Period code with expected length in ms; code 4 sets 100 ms integration.
  int per[4][2] = '{'{0, 250}, '{1, 500}, '{2, 1000}, '{4, 1000}};
  // Mode word, first input, second input, contact, expected value.
  int sw[9][5] = '{'{2, -5, 200, 0, -5}, '{2, 50, 60, 0, 55},
    '{2, 90, 150, 0, 150}, '{6, 100, 300, 0, 100}, '{6, 101, 300, 0, 300},
    '{6, 97, 300, 0, 300}, '{6, 95, 300, 0, 95}, '{10, 40, 70, 0, 40},
    '{10, 40, 70, 1, 70}};

  cps_selector #(.MS_CYCLES(MS)) i_cps_selector (.clock, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .first_measured_input, .second_measured_input, .computed_pv,
    .computed_out, .pid_out, .pv_switch_contact, .power_good,
    .program_active, .period_tick, .pv_q, .setpoint_q,
    .secondary_setpoint_q, .ctrl_out_q, .group_q, .loop_mode,
    .restart_action_q, .restart_pulse_q);

  cps_field i_cps_field (.clock(clock), .pv_a(first_measured_input),
    .pv_b(second_measured_input), .contact(pv_switch_contact),
    .power(power_good));

  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Zone index: how many of the five references lie at or below pv.
  function int zexp(input int p);
    int c;
    c = 0;
    for (int i = 0; i < 5; i++) begin
      c += (p >= 100 * i);
    end
    return c;
  endfunction : zexp

  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk(d, e);
  endtask : rc

  task automatic cfgw(input int gr, input logic [31:0] x);
    wr(CPS_CFG_ADDR, (32'(gr) << CPS_CFG_GROUPS) | x);
  endtask : cfgw

  // Counts cycles to the next tick; a missing tick ends the run.
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(negedge clock);
      c++;
      if (c > 25000) begin
        failures++;
        stop_test();
      end
    end while (period_tick !== 1'b1);
  endtask : wait_tick

  // Lets the tick land, then one more cycle for the group to follow.
  task automatic pvs(input int a, input int b, input bit c);
    i_cps_field.set_in(a, b, c);
    wait_tick(n);
    repeat (2) @(negedge clock);
  endtask : pvs

  task automatic mode(input logic [31:0] w);
    wr(CPS_MODE_ADDR, w);
    repeat (3) @(negedge clock);
  endtask : mode

  task automatic pw(input int c, input int e);
    i_cps_field.outage(c);
    n = 0;
    while (restart_pulse_q !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    chk(n < 50, 1);
    chk(restart_action_q, e);
  endtask : pw

  // Main sequence: reset, then one scenario group per concern.
  initial begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 40'h0};
    {program_active, computed_pv, computed_out, pid_out} = '0;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    rc(CPS_PID_ADDR, {CPS_TEMP_TD, CPS_TEMP_TI, CPS_TEMP_PB});
    rc(CPS_STAT_ADDR, 32'(250) << 2);
    rc(8'h3c, 0);
    cfgw(7, 32'h1400);
    rc(CPS_PID_ADDR, {CPS_FLOW_TD, CPS_FLOW_TI, CPS_FLOW_PB});
    foreach (per[i]) begin
      cfgw(7, per[i][0]);
      wait_tick(n);
      wait_tick(n);
      chk(n, per[i][1] * MS);
    end
    for (int i = 0; i < 8; i++) begin
      g = xs() % 8;
      cfgw(g, 0);
      wr(CPS_SPSEL_ADDR, 32'(i));
      repeat (3) @(negedge clock);
      chk(group_q, i > g ? g : i);
    end
    // A rising setpoint climbs 30 a period; a falling one steps.
    cfgw(7, 0);
    wr(CPS_SP_BASE + 8'h04, 32'd100);
    wr(CPS_SPSEL_ADDR, 0);
    pvs(0, 0, 0);
    wr(CPS_RAMP_ADDR, 32'h1e);
    wr(CPS_SPSEL_ADDR, 1);
    for (int i = 1; i < 5; i++) begin
      v = int'(xs() % 2000) - 1000;
      pvs(v, 0, 0);
      chk(setpoint_q, i < 4 ? 30 * i : 100);
      chk(pv_q, v);
    end
    wr(CPS_SPSEL_ADDR, 0);
    pvs(0, 0, 0);
    chk(setpoint_q, 0);
    // Seven groups: five references, the sixth is a trap if counted.
    cfgw(6, 1 << CPS_CFG_ZONE);
    for (int i = 0; i < 6; i++) begin
      wr(CPS_REF_BASE + 8'(4 * i), i < 5 ? 32'(100 * i) : 32'h8000);
    end
    repeat (6) begin
      v = int'(xs() % 700) - 100;
      pvs(v, 0, 0);
      chk(group_q, zexp(v));
    end
    wr(CPS_DEV_ADDR, 32'h03e8_0032);
    pvs(-50, 0, 0);
    chk(group_q, 0);
    pvs(-1000, 0, 0);
    chk(group_q, 6);
    cfgw(7, 0);
    wr(CPS_SWLIM_ADDR, 32'h0064_0000);
    foreach (sw[i]) begin
      if (i == 0 || sw[i][0] != sw[i-1][0]) begin
        wr(CPS_MODE_ADDR, 32'(sw[i][0]));
      end
      pvs(sw[i][1], sw[i][2], sw[i][3]);
      chk(pv_q, sw[i][4]);
    end
    wr(CPS_OUTLIM_ADDR, 32'h0064_0000);
    pid_out <= 16'sd500;
    computed_out <= -16'sd700;
    mode(32'h1);
    chk(secondary_setpoint_q, 500);
    mode(32'h3);
    chk(ctrl_out_q, -700);
    mode(32'h0);
    chk(ctrl_out_q, 100);
    chk(secondary_setpoint_q, 0);
    mode(32'h1_1321);
    chk(loop_mode, 12'h079);
    cfgw(7, 1 << CPS_CFG_LOOPS4);
    @(negedge clock);
    chk(loop_mode, 12'h179);
    mode(32'h0);
    cfgw(7, 1 << CPS_CFG_PVCALC);
    computed_pv <= 16'(xs());
    pvs(0, 0, 0);
    chk(pv_q, computed_pv);
    cfgw(7, 1 << CPS_CFG_RESTART);
    pw(2000, 0);
    pw(12000, 1);
    // Auto restart while a program runs falls back to continue.
    cfgw(7, 2 << CPS_CFG_RESTART);
    program_active <= 1'b1;
    pw(12000, 0);
    stop_test();
  end
endmodule : control_loop_pid_selector_test
`default_nettype wire
